//--- hdl/encoder_turns_and_line_count_config.sv
// Encoder turns-bit, linear ratio and line-count configuration with derived feedback settings.
// Assumes registers reached over a plain strobe port on sys_clk_i; encoder-side inputs are
// produced by logic on the same clock.
`timescale 1ns/1ps
`include "enc_cfg_map.svh"

// Overview of operation
// - Linear comms encoder: revolution counter unmasked, full 16 bits, maximum 65535.
// - Linear comms: setting is sine period over position LSB, used at initialisation.
// - Auto-configured ratio above 255 kept internally; visible setting shows 255.
// - Hidden ratio above 255 blocks writes; cleared by power cycle or small-ratio autoconfig.
// - Enabled or saved autoconfig runs at power-up and every encoder initialisation.
// - Serial absolute: read that many turns bits, none at zero; same mask on counter.
// - Turns setting above 16 acts as 16 turns bits.
// - Line count range 0 to 50000; minimum 1 except servo commutation or comms-only.
// - Line count defaults 1024 open/closed-loop, 4096 in servo mode.
// - New line count applied only while the drive is disabled.
// - Equivalent lines: quadrature as is, freq/dir and fwd/rev halved, sincos periods.
// - Linear encoder revolution is pole pitch times configured poles.
// - Servo commutation type with zero lines uses commutation signals alone.
// - Line count or pole pairs change with commutation type re-initialises encoder.
// - Interpolation up to 11 bits, nominal 10; total resolution adds line bits.
// - Rotary sincos comms encoder forces line count to power of two 2..32768.
// - Any line count register write raises the encoder re-initialisation trip.
// - Non-power-of-two linear: 6kHz current sampling at 6 or 12kHz switching.
// - Comms-only feedback ignores line count; successful autoconfig sets it zero.
// - Rotary counter held at zero for zero turns, else wraps at 2^n-1.
module encoder_turns_and_line_count_config #(
  parameter int ADDR_W = 4,  // Register address width
  parameter int DATA_W = 16  // Register data width
) (
  input wire logic sys_clk_i,                    // System clock, 20 MHz
  input wire logic rst_n_i,                      // Synchronous reset, active low
  input wire logic [ADDR_W-1:0] reg_addr_i,      // Register address
  input wire logic [DATA_W-1:0] reg_wdata_i,     // Register write data
  input wire logic reg_wr_i,                     // Write strobe
  input wire logic reg_rd_i,                     // Read strobe
  output logic [DATA_W-1:0] reg_rdata_o,         // Read data, cycle after strobe
  input wire logic drive_enabled_i,              // Drive enabled level
  input wire logic auto_config_saved_i,          // Saved auto-configuration enable
  input wire logic encoder_init_req_i,           // Encoder initialisation pulse
  input wire logic autocfg_done_i,               // Auto-configuration finished pulse
  input wire logic autocfg_ok_i,                 // Auto-configuration succeeded
  input wire logic [15:0] autocfg_ratio_i,       // Read-back linear ratio
  input wire logic [7:0] autocfg_turns_i,        // Read-back turns bits
  input wire logic [15:0] autocfg_lines_i,       // Read-back sine periods
  input wire logic rev_inc_i,                    // Revolution up pulse
  input wire logic rev_dec_i,                    // Revolution down pulse
  input wire logic comms_turns_valid_i,          // Serial turns word valid
  input wire logic [15:0] comms_turns_i,         // Serial turns word
  input wire logic [3:0] interp_bits_i,          // Measured interpolation bits
  output logic autocfg_req_o,                    // Start auto-configuration pulse
  output logic encoder_reinit_o,                 // Re-initialise encoder pulse
  output logic encoder_reinit_trip_o,            // Re-initialisation trip level
  output logic [4:0] comms_turns_bits_o,         // Turns bits to read from message
  output logic [15:0] linear_ratio_o,            // Effective linear ratio
  output logic [15:0] line_count_applied_o,      // Line count in use
  output logic [15:0] equivalent_line_count_o,   // Equivalent line count
  output logic [15:0] revolution_counter_o,      // Displayed revolutions
  output logic hall_only_o,                      // Position from commutation signals only
  output logic reduced_sample_o,                 // Current loop at 6kHz
  output logic [4:0] total_res_bits_o,           // Resolution in bits per revolution
  output logic [24:0] linear_rev_length_o        // Linear revolution length
);

  generate
    if (ADDR_W != 4 || DATA_W != 16) begin : g_check
      $error("encoder config: ADDR_W must be 4 and DATA_W 16");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] turns_reg, turns_next;
  logic [15:0] lines_reg, lines_next;
  logic [15:0] cfg_reg, cfg_next;
  logic [15:0] poles_reg, poles_next;
  logic [15:0] pitch_reg, pitch_next;
  logic [15:0] hidden_reg, hidden_next;
  logic hidden_on_reg, hidden_on_next;
  logic trip_reg, trip_next;
  logic first_reg;
  logic [15:0] applied_reg, applied_next;
  logic [7:0] prev_pp_reg;
  logic [15:0] prev_lines_reg;
  logic [15:0] rev_reg, rev_next;
  logic [15:0] rdata_reg, rdata_next;
  logic req_reg, reinit_reg;
  logic [15:0] equiv_reg;
  logic hall_reg, reduced_reg;
  logic [4:0] res_reg;
  logic [24:0] rev_len_reg;
  logic [4:0] bits_reg;
  logic [15:0] ratio_reg;

  pow2_if wr_p ();
  pow2_if eq_p ();
  pow2_if ap_p ();

  pow2_round u_wr_pow2 (.p(wr_p));
  pow2_round u_eq_pow2 (.p(eq_p));
  pow2_round u_ap_pow2 (.p(ap_p));

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire enc_cfg_pkg::enc_type_t enc_type = enc_cfg_pkg::enc_type_t'(cfg_reg[`CFG_TYPE_MSB:`CFG_TYPE_LSB]);
  wire enc_cfg_pkg::drive_mode_t mode = enc_cfg_pkg::drive_mode_t'(cfg_reg[`CFG_MODE_MSB:`CFG_MODE_LSB]);
  wire enc_cfg_pkg::sw_freq_t swf = enc_cfg_pkg::sw_freq_t'(cfg_reg[`CFG_SWF_MSB:`CFG_SWF_LSB]);
  wire [1:0] sel = cfg_reg[`CFG_SEL_MSB:`CFG_SEL_LSB];
  wire is_linear = (sel == `SEL_LINEAR);

  wire is_comm = (enc_type == enc_cfg_pkg::quadrature_commutation_encoder) ||
                 (enc_type == enc_cfg_pkg::freq_dir_commutation_encoder) ||
                 (enc_type == enc_cfg_pkg::fwd_rev_commutation_encoder);
  wire is_halved = (enc_type == enc_cfg_pkg::freq_dir_encoder) || (enc_type == enc_cfg_pkg::fwd_rev_encoder) ||
                   (enc_type == enc_cfg_pkg::freq_dir_commutation_encoder) ||
                   (enc_type == enc_cfg_pkg::fwd_rev_commutation_encoder);
  wire is_sc_comms = (enc_type == enc_cfg_pkg::sincos_async_comms_encoder) ||
                     (enc_type == enc_cfg_pkg::sincos_bidir_comms_encoder) ||
                     (enc_type == enc_cfg_pkg::sincos_synchronous_serial_encoder);
  wire is_comms_only = (enc_type == enc_cfg_pkg::bidir_comms_only_encoder) ||
                       (enc_type == enc_cfg_pkg::synchronous_serial_only_encoder);

  wire is_sincos = is_sc_comms || (enc_type == enc_cfg_pkg::sincos_encoder);
  wire is_serial = is_sc_comms || is_comms_only;
  wire linear_comms = is_serial && is_linear;

  wire wr_turns = reg_wr_i && (reg_addr_i == `REG_TURNS);
  wire wr_lines = reg_wr_i && (reg_addr_i == `REG_LINES);
  wire wr_cfg = reg_wr_i && (reg_addr_i == `REG_CFG);
  wire wr_poles = reg_wr_i && (reg_addr_i == `REG_POLES);
  wire wr_status = reg_wr_i && (reg_addr_i == `REG_STATUS);
  wire wr_pitch = reg_wr_i && (reg_addr_i == `REG_PITCH);

  wire auto_ok = autocfg_done_i && autocfg_ok_i;

  wire [4:0] turns_eff = (turns_reg > {3'h0, `TURNS_MAX_BITS}) ? `TURNS_MAX_BITS : turns_reg[4:0];
  wire [16:0] mask_wide = (17'h00001 << turns_eff) - 17'h00001;
  wire [15:0] rev_mask = linear_comms ? 16'hffff : mask_wide[15:0];

  // ----------------------------------------------------------------
  // Line count write path
  // ----------------------------------------------------------------
  // range and minimum
  wire min_exempt = (is_comm && (mode == enc_cfg_pkg::mode_servo)) || is_comms_only;
  wire [15:0] wr_hi = (reg_wdata_i > `LINES_MAX) ? `LINES_MAX : reg_wdata_i;
  wire [15:0] wr_lim = (!min_exempt && (wr_hi < `LINES_MIN)) ? `LINES_MIN : wr_hi;
  // Reply borrows the analyser
  assign wr_p.value = auto_ok ? autocfg_lines_i : wr_lim;
  // rotary sincos comms power of two
  wire force_pow2 = is_sc_comms && !is_linear;
  wire [15:0] wr_line_val = force_pow2 ? wr_p.nearest : wr_lim;

  wire [1:0] new_mode = reg_wdata_i[`CFG_MODE_MSB:`CFG_MODE_LSB];
  wire [15:0] mode_default = (new_mode == enc_cfg_pkg::mode_servo) ? `LINES_SERVO_DEFAULT : `LINES_OPEN_DEFAULT;
  wire mode_change = wr_cfg && (new_mode != cfg_reg[`CFG_MODE_MSB:`CFG_MODE_LSB]);

  // ----------------------------------------------------------------
  // Derived values
  // ----------------------------------------------------------------
  wire [7:0] pp_active = cfg_reg[`CFG_MAP_BIT] ? poles_reg[15:8] : poles_reg[7:0];
  wire [15:0] equiv_val = is_halved ? {1'b0, applied_reg[15:1]} : applied_reg;
  assign eq_p.value = equiv_reg;
  assign ap_p.value = applied_reg;

  wire [3:0] interp_cap = (interp_bits_i > `INTERP_MAX) ? `INTERP_MAX : interp_bits_i;
  wire [4:0] res_val = {1'b0, eq_p.msb_pos} + (is_sincos ? {1'b0, interp_cap} : 5'h00);

  wire reduced_val = !ap_p.is_pow2 && is_linear && ((swf == enc_cfg_pkg::swf_6k) || (swf == enc_cfg_pkg::swf_12k));
  wire hall_val = is_comm && (applied_reg == 16'h0000);

  wire [24:0] rev_len_val = 25'(pitch_reg * {pp_active, 1'b0});

  wire reinit_val = is_comm && ((applied_reg != prev_lines_reg) || (pp_active != prev_pp_reg));
  wire auto_en = cfg_reg[`CFG_AUTO_BIT] || auto_config_saved_i;
  wire req_val = auto_en && (first_reg || encoder_init_req_i);

  wire [4:0] bits_val = (turns_next > {3'h0, `TURNS_MAX_BITS}) ? `TURNS_MAX_BITS : turns_next[4:0];
  wire [15:0] ratio_val = hidden_on_next ? hidden_next : {8'h00, turns_next};

  // ----------------------------------------------------------------
  // Next-state
  // ----------------------------------------------------------------
  always_comb begin
    turns_next = turns_reg;
    hidden_next = hidden_reg;
    hidden_on_next = hidden_on_reg;
    lines_next = lines_reg;

    if (wr_turns && !hidden_on_reg) begin
      turns_next = reg_wdata_i[7:0];
    end
    if (mode_change) begin
      lines_next = mode_default;
    end
    if (wr_lines) begin
      lines_next = wr_line_val;
    end
    if (auto_ok) begin
      if (linear_comms) begin
        hidden_next = autocfg_ratio_i;
        hidden_on_next = (autocfg_ratio_i > {8'h00, `TURNS_VISIBLE_MAX});
        turns_next = hidden_on_next ? `TURNS_VISIBLE_MAX : autocfg_ratio_i[7:0];
      end else begin
        turns_next = autocfg_turns_i;
      end
      if (is_comms_only) begin
        lines_next = 16'h0000;
      end else if (is_sc_comms) begin
        lines_next = force_pow2 ? wr_p.nearest : autocfg_lines_i;
      end
    end
  end

  assign trip_next = wr_lines || (trip_reg && !(wr_status && reg_wdata_i[`ST_TRIP_BIT]));
  assign applied_next = drive_enabled_i ? applied_reg : lines_reg;
  assign cfg_next = wr_cfg ? reg_wdata_i : cfg_reg;
  assign poles_next = wr_poles ? reg_wdata_i : poles_reg;
  assign pitch_next = wr_pitch ? reg_wdata_i : pitch_reg;

  assign rev_next = (comms_turns_valid_i && is_serial) ? (comms_turns_i & rev_mask) :
                    rev_inc_i ? ((rev_reg + 16'h0001) & rev_mask) :
                    rev_dec_i ? ((rev_reg - 16'h0001) & rev_mask) : (rev_reg & rev_mask);

  wire [15:0] status_word = {7'h00, res_reg, reduced_reg, hall_reg, hidden_on_reg, trip_reg};

  assign rdata_next = !reg_rd_i ? 16'h0000 :
                      (reg_addr_i == `REG_TURNS) ? {8'h00, turns_reg} :
                      (reg_addr_i == `REG_LINES) ? lines_reg :
                      (reg_addr_i == `REG_CFG) ? cfg_reg :
                      (reg_addr_i == `REG_POLES) ? poles_reg :
                      (reg_addr_i == `REG_STATUS) ? status_word :
                      (reg_addr_i == `REG_HIDDEN) ? hidden_reg :
                      (reg_addr_i == `REG_EQUIV) ? equiv_reg :
                      (reg_addr_i == `REG_REVS) ? rev_reg :
                      (reg_addr_i == `REG_PITCH) ? pitch_reg : 16'h0000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      turns_reg <= `TURNS_RESET;
      lines_reg <= `LINES_OPEN_DEFAULT;
      cfg_reg <= 16'h0000;
      poles_reg <= `POLES_RESET;
      pitch_reg <= `PITCH_RESET;
      hidden_reg <= 16'h0000;
      hidden_on_reg <= 1'b0;
      trip_reg <= 1'b0;
      first_reg <= 1'b1;
      applied_reg <= `LINES_OPEN_DEFAULT;
      prev_lines_reg <= `LINES_OPEN_DEFAULT;
      prev_pp_reg <= 8'h03;
      rev_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
    end else begin
      turns_reg <= turns_next;
      lines_reg <= lines_next;
      cfg_reg <= cfg_next;
      poles_reg <= poles_next;
      pitch_reg <= pitch_next;
      hidden_reg <= hidden_next;
      hidden_on_reg <= hidden_on_next;
      trip_reg <= trip_next;
      first_reg <= 1'b0;
      applied_reg <= applied_next;
      prev_lines_reg <= applied_reg;
      prev_pp_reg <= pp_active;
      rev_reg <= rev_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      req_reg <= 1'b0;
      reinit_reg <= 1'b0;
      equiv_reg <= `LINES_OPEN_DEFAULT;
      hall_reg <= 1'b0;
      reduced_reg <= 1'b0;
      res_reg <= {1'b0, `INTERP_NOMINAL};
      rev_len_reg <= 25'h0000000;
      bits_reg <= `TURNS_MAX_BITS;
      ratio_reg <= {8'h00, `TURNS_RESET};
    end else begin
      req_reg <= req_val;
      reinit_reg <= reinit_val;
      equiv_reg <= equiv_val;
      hall_reg <= hall_val;
      reduced_reg <= reduced_val;
      res_reg <= res_val;
      rev_len_reg <= rev_len_val;
      bits_reg <= bits_val;
      ratio_reg <= ratio_val;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o = rdata_reg;
  assign autocfg_req_o = req_reg;
  assign encoder_reinit_o = reinit_reg;
  assign encoder_reinit_trip_o = trip_reg;
  assign comms_turns_bits_o = bits_reg;
  assign linear_ratio_o = ratio_reg;
  assign line_count_applied_o = applied_reg;
  assign equivalent_line_count_o = equiv_reg;
  assign revolution_counter_o = rev_reg;
  assign hall_only_o = hall_reg;
  assign reduced_sample_o = reduced_reg;
  assign total_res_bits_o = res_reg;
  assign linear_rev_length_o = rev_len_reg;

endmodule : encoder_turns_and_line_count_config

//--- hdl/enc_cfg_map.svh
// Register offsets, field positions, reset values and limits of the encoder configuration block.
// Assumes inclusion by bare name from the top module.
`ifndef ENC_CFG_MAP_SVH
`define ENC_CFG_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_TURNS 4'h0
`define REG_LINES 4'h1
`define REG_CFG 4'h2
`define REG_POLES 4'h3
`define REG_STATUS 4'h4
`define REG_HIDDEN 4'h5
`define REG_EQUIV 4'h6
`define REG_REVS 4'h7
`define REG_PITCH 4'h8

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_TYPE_LSB 0
`define CFG_TYPE_MSB 3
`define CFG_SEL_LSB 4
`define CFG_SEL_MSB 5
`define CFG_AUTO_BIT 6
`define CFG_MODE_LSB 7
`define CFG_MODE_MSB 8
`define CFG_SWF_LSB 9
`define CFG_SWF_MSB 11
`define CFG_MAP_BIT 12

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ST_TRIP_BIT 0
`define ST_HIDDEN_BIT 1
`define ST_HALL_BIT 2
`define ST_REDUCED_BIT 3
`define ST_RES_LSB 4
`define ST_RES_MSB 8

// ----------------------------------------------------------------
// Values and limits
// ----------------------------------------------------------------
`define TURNS_RESET 8'h10
`define TURNS_MAX_BITS 5'h10
`define TURNS_VISIBLE_MAX 8'hff
`define LINES_OPEN_DEFAULT 16'h0400
`define LINES_SERVO_DEFAULT 16'h1000
`define LINES_MAX 16'hc350
`define LINES_MIN 16'h0001
`define POW2_MIN 16'h0002
`define POW2_MAX 16'h8000
`define POLES_RESET 16'h0303
`define PITCH_RESET 16'h0000
`define INTERP_MAX 4'hb
`define INTERP_NOMINAL 4'ha
`define SEL_LINEAR 2'h0

`endif

//--- hdl/enc_cfg_pkg.sv
// Types shared by the encoder configuration block.
// Assumes enc_cfg_map.svh is on the include path.
package enc_cfg_pkg;

  typedef enum logic [3:0] {
    quadrature_encoder = 4'h0,
    freq_dir_encoder = 4'h1,
    fwd_rev_encoder = 4'h2,
    quadrature_commutation_encoder = 4'h3,
    freq_dir_commutation_encoder = 4'h4,
    fwd_rev_commutation_encoder = 4'h5,
    sincos_encoder = 4'h6,
    sincos_async_comms_encoder = 4'h7,
    sincos_bidir_comms_encoder = 4'h8,
    sincos_synchronous_serial_encoder = 4'h9,
    bidir_comms_only_encoder = 4'ha,
    synchronous_serial_only_encoder = 4'hb
  } enc_type_t;

  typedef enum logic [1:0] {
    mode_open_loop = 2'h0,
    mode_closed_loop = 2'h1,
    mode_servo = 2'h2
  } drive_mode_t;

  typedef enum logic [2:0] {
    swf_3k = 3'h0,
    swf_4k5 = 3'h1,
    swf_6k = 3'h2,
    swf_8k = 3'h3,
    swf_12k = 3'h4,
    swf_16k = 3'h5
  } sw_freq_t;

endpackage : enc_cfg_pkg

//--- hdl/pow2_if.sv
// Carrier between the top module and a power-of-two analyser instance.
// Assumes the analyser is purely combinational.
`timescale 1ns/1ps
interface pow2_if;
  logic [15:0] value;
  logic [15:0] nearest;
  logic [3:0] msb_pos;
  logic is_pow2;
  modport user (output value, input nearest, input msb_pos, input is_pow2);
  modport calc (input value, output nearest, output msb_pos, output is_pow2);
endinterface : pow2_if

//--- hdl/pow2_round.sv
// Power-of-two analyser: highest set bit, exact test, nearest clamped power of two.
// Assumes a 16-bit value on the carrier; results settle in the same cycle.
`timescale 1ns/1ps
module pow2_round (
  pow2_if.calc p  // Value in, analysis out
);
  logic [15:0] onehot;
  logic [16:0] upper;
  logic [16:0] span_lo;
  logic [16:0] span_hi;
  logic [15:0] raw_near;
  logic [3:0] pos;

  // ----------------------------------------------------------------
  // Highest set bit as a one-hot word
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 16; b++) begin : g_msb
      if (b == 15) begin : g_top
        assign onehot[b] = p.value[b];
      end else begin : g_low
        assign onehot[b] = p.value[b] & ~|p.value[15:b+1];
      end
    end
  endgenerate

  always_comb begin
    pos = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (onehot[i]) begin
        pos = i[3:0];
      end
    end
  end

  assign upper = {onehot, 1'b0};
  assign span_lo = {1'b0, p.value} - {1'b0, onehot};
  assign span_hi = upper - {1'b0, p.value};
  assign raw_near = (span_lo >= span_hi) ? upper[15:0] : onehot;
  assign p.nearest = (p.value <= `POW2_MIN) ? `POW2_MIN :
                     ((onehot[15] || upper[16]) ? `POW2_MAX : raw_near);
  assign p.msb_pos = pos;
  assign p.is_pow2 = (p.value == onehot) && (p.value != 16'h0000);
endmodule : pow2_round

//--- tb/enc_model.sv
// Encoder far side: answers an auto-configuration request a few cycles later.
// Assumes the request is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module enc_model (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic req_i, // Start request
  input wire logic [15:0] ratio_set_i, // Ratio to report
  output logic done_o, // Reply pulse
  output logic [15:0] ratio_o, // Ratio
  output logic [7:0] turns_o, // Turns bits
  output logic [15:0] lines_o // Sine periods
);
  logic [1:0] wait_reg = 2'h0;
  always_ff @(posedge clk_i) begin
    wait_reg <= !rst_n_i ? 2'h0 : req_i ? 2'h3 : (wait_reg != 2'h0 ? wait_reg - 2'h1 : 2'h0);
    done_o <= wait_reg == 2'h1;
    ratio_o <= wait_reg == 2'h1 ? ratio_set_i : ~ratio_o;
    turns_o <= wait_reg == 2'h1 ? 8'h0c : ~turns_o;
    lines_o <= wait_reg == 2'h1 ? 16'h0800 : ~lines_o;
  end
endmodule : enc_model

//--- tb/enc_cfg_chk.sv
// Port checks for the encoder configuration block.
// Assumes it is bound into the top module; one clock, synchronous reset.
`timescale 1ns/1ps
module enc_cfg_chk #(
  parameter int ADDR_W = 4, // Address width
  parameter int DATA_W = 16 // Data width
) (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic [ADDR_W-1:0] reg_addr_i, // Address
  input wire logic [DATA_W-1:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write
  input wire logic reg_rd_i, // Read
  input wire logic [DATA_W-1:0] reg_rdata_o, // Read data
  input wire logic drive_enabled_i, // Enabled
  input wire logic auto_config_saved_i, // Saved enable
  input wire logic encoder_init_req_i, // Init
  input wire logic autocfg_req_o, // Request
  input wire logic encoder_reinit_trip_o, // Trip
  input wire logic [4:0] comms_turns_bits_o, // Turns bits
  input wire logic [15:0] line_count_applied_o, // Lines
  input wire logic reduced_sample_o // Reduced rate
);
  default clocking dcb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_lines_wr;
    reg_wr_i && reg_addr_i == 4'h1;
  endsequence
  sequence s_trip_clr;
    reg_wr_i && reg_addr_i == 4'h4 && reg_wdata_i[0];
  endsequence
  sequence s_init;
    encoder_init_req_i && auto_config_saved_i;
  endsequence
  a_read_idle:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0) else $error("Read data outside slot");
  a_lines_trip:
    assert property (s_lines_wr |=> encoder_reinit_trip_o) else $error("No trip after line write");
  a_trip_hold:
    assert property (encoder_reinit_trip_o && !(reg_wr_i && reg_addr_i == 4'h4 && reg_wdata_i[0])
      |=> encoder_reinit_trip_o) else $error("Trip dropped");
  a_trip_clear:
    assert property (s_trip_clr |=> !encoder_reinit_trip_o) else $error("Trip not cleared");
  a_applied_hold:
    assert property ($past(drive_enabled_i) |-> $stable(line_count_applied_o)) else $error("Lines moved");
  a_lines_max:
    assert property (line_count_applied_o <= 16'hc350) else $error("Lines above range");
  a_autocfg_start:
    assert property (s_init |=> autocfg_req_o ##1 !autocfg_req_o) else $error("No config request");
  a_reduced_rate:
    assert property (reduced_sample_o |-> ($past(line_count_applied_o) & ($past(line_count_applied_o)
      - 16'h1)) != 16'h0) else $error("Reduced rate on power of two");
  a_turns_cap:
    assert property (comms_turns_bits_o <= 5'h10) else $error("Turns bits above 16");
endmodule : enc_cfg_chk
bind encoder_turns_and_line_count_config enc_cfg_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_u (.*);

//--- tb/encoder_turns_and_line_count_config_tb.sv
// Self-checking bench for the encoder configuration block.
// Assumes the checker is bound and enc_model answers auto-configuration.
`timescale 1ns/1ps
module encoder_turns_and_line_count_config_tb;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, drive_enabled_i = 1'b0;
  logic auto_config_saved_i = 1'b0, encoder_init_req_i = 1'b0, rev_inc_i = 1'b0, rev_dec_i = 1'b0;
  logic comms_turns_valid_i = 1'b0, autocfg_done_i, autocfg_ok_i;
  logic [3:0] reg_addr_i = 4'h0, interp_bits_i = 4'ha;
  logic [15:0] reg_wdata_i = 16'h0, comms_turns_i = 16'h0, ratio_set = 16'h0, v;
  logic [15:0] autocfg_ratio_i, autocfg_lines_i, reg_rdata_o, linear_ratio_o, line_count_applied_o;
  logic [15:0] equivalent_line_count_o, revolution_counter_o;
  logic [7:0] autocfg_turns_i;
  logic [4:0] comms_turns_bits_o, total_res_bits_o;
  logic [24:0] linear_rev_length_o;
  logic autocfg_req_o, encoder_reinit_o, encoder_reinit_trip_o, hall_only_o, reduced_sample_o;
  int err_total = 0, n_tests = 0, cyc = 0;
  assign autocfg_ok_i = autocfg_done_i;
  encoder_turns_and_line_count_config dut_u (.*);
  enc_model model_u (.clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(autocfg_req_o), .ratio_set_i(ratio_set),
    .done_o(autocfg_done_i), .ratio_o(autocfg_ratio_i), .turns_o(autocfg_turns_i), .lines_o(autocfg_lines_i));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  task automatic complete_run;
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      complete_run;
    end
  end
  task automatic chk(input logic [24:0] g, input logic [24:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wt
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task automatic acfg(input logic [15:0] r);
    @(posedge sys_clk_i);
    ratio_set <= r;
    auto_config_saved_i <= 1'b1;
    encoder_init_req_i <= 1'b1;
    @(posedge sys_clk_i);
    encoder_init_req_i <= 1'b0;
    wt(8);
  endtask : acfg
  task automatic t_regs;
    rd(4'h1); chk(v, 16'h0400);
    rd(4'h3); chk(v, 16'h0303);
    rd(4'hf); chk(v, 16'h0000);
    wr(4'h1, 16'hea60); rd(4'h1); chk(v, 16'hc350);
    wr(4'h1, 16'h0000); rd(4'h1); chk(v, 16'h0001);
    rd(4'h4); chk(v[0], 1'b1);
    wr(4'h4, 16'h0001); rd(4'h4); chk(v[0], 1'b0);
    $display("regs done");
  endtask : t_regs
  task automatic t_revs;
    wr(4'h0, 16'h0002);
    for (int i = 1; i < 5; i++) begin
      @(posedge sys_clk_i);
      rev_inc_i <= 1'b1;
      @(posedge sys_clk_i);
      rev_inc_i <= 1'b0;
      wt(1);
      chk(revolution_counter_o, 25'(i % 4));
    end
    chk(revolution_counter_o, 16'h0000);
    chk(comms_turns_bits_o, 5'h02);
    $display("revs done");
  endtask : t_revs
  task automatic t_applied;
    wr(4'h2, 16'h0400);
    drive_enabled_i <= 1'b1;
    wr(4'h1, 16'h03e8); wt(3); chk(line_count_applied_o, 16'h0001);
    drive_enabled_i <= 1'b0;
    wt(3); chk(line_count_applied_o, 16'h03e8);
    chk(reduced_sample_o, 1'b1);
    chk(equivalent_line_count_o, 16'h03e8);
    chk(total_res_bits_o, 5'h09);
    wr(4'h2, 16'h0401); wt(3); chk(equivalent_line_count_o, 16'h01f4);
    wr(4'h8, 16'h0010);
    wt(1);
    chk(linear_rev_length_o, 25'h0000060);
    $display("applied done");
  endtask : t_applied
  task automatic t_pow2;
    wr(4'h2, 16'h0117); rd(4'h1); chk(v, 16'h1000);
    wr(4'h1, 16'h0bb8); rd(4'h1); chk(v, 16'h0800);
    wr(4'h1, 16'h0001); rd(4'h1); chk(v, 16'h0002);
    wr(4'h1, 16'hc350); rd(4'h1); chk(v, 16'h8000);
    $display("pow2 done");
  endtask : t_pow2
  task automatic t_comm;
    wr(4'h2, 16'h0103);
    wr(4'h1, 16'h0000);
    wt(2);
    chk(encoder_reinit_o, 1'b1);
    chk(hall_only_o, 1'b1);
    wt(1);
    chk(encoder_reinit_o, 1'b0);
    $display("comm done");
  endtask : t_comm
  task automatic t_hidden;
    wr(4'h2, 16'h0108); acfg(16'h012c); rd(4'h0); chk(v, 16'h00ff);
    chk(linear_ratio_o, 16'h012c);
    wr(4'h0, 16'h0005); rd(4'h0); chk(v, 16'h00ff);
    acfg(16'h0064); rd(4'h0); chk(v, 16'h0064);
    wr(4'h2, 16'h010a); acfg(16'h0064); rd(4'h1); chk(v, 16'h0000);
    comms_turns_i <= 16'habcd;
    comms_turns_valid_i <= 1'b1;
    wt(1);
    comms_turns_valid_i <= 1'b0;
    chk(revolution_counter_o, 16'habcd);
    $display("hidden done");
  endtask : t_hidden
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_revs;
    t_applied;
    t_pow2;
    t_comm;
    t_hidden;
    complete_run;
  end
endmodule : encoder_turns_and_line_count_config_tb
